/* verilog/smc_sleep_ctrl.sv */
// Sleep mode controller top: entry, clock gating and wake sequencing
`timescale 1ns/10ps
`include "smc_regs.svh"
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int STARTUP_W = 16 // Width of start-up count
) (
    input wire logic mclk, // 25 MHz clock
    input wire logic reset, // Sync reset, active high
    input wire logic sleep_exec, // Sleep instruction pulse
    input wire logic ctrl_we, // Control write strobe
    input wire logic [3:0] ctrl_wdata, // Mode select and enable
    input wire logic [STARTUP_W-1:0] clock_source_fuses, // Startup cycles
    input wire logic any_reset, // Any reset source, pin
    input wire logic [3:0] external_irq_lines, // Level irq pins
    input wire logic [3:0] ext_irq_edge, // Edge irq events, pins
    input wire logic pin_change, // Pin change event, pin
    input wire logic comm_req, // Comm request, pin
    input wire logic card_evt, // Card insert/remove, pin
    input wire logic key_press, // Keypad press, pin
    input wire logic wdt_irq, // Watchdog irq
    input wire logic t2_ovf, // Timer two overflow
    input wire logic t2_cmp, // Timer two compare
    input wire logic [1:0] timer_two_irq_mask, // Timer two irq enables
    input wire logic global_irq_en, // Global irq enable
    input wire logic mem_ready, // Memory ready irq
    input wire logic other_io, // Other I/O irq
    input wire logic t2_enabled, // Timer two running
    input wire logic t2_async, // Timer two on async clock
    output logic [3:0] sleep_control_register, // Mode and enable readback
    output logic sleeping, // Low-power state active
    output logic cpu_hold, // CPU halted
    output logic resume_pulse, // Resume after sleep
    output logic vector_restart, // Restart at reset vector
    output smc_clk_t clk_en, // Clock domain enables
    output logic t2_sync_clk_en // Sync clock to timer two
);
    smc_state_t state_q;
    smc_state_t state_d;
    logic [3:0] ctrl_q;
    logic [2:0] mode_q;
    logic [STARTUP_W-1:0] cnt_q;
    logic [3:0] halt_q;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [3:0] lvl1_q;
    logic [3:0] lvl2_q;
    logic [3:0] edg1_q;
    logic [3:0] edg2_q;
    logic [1:0] rst_sync_q;
    logic sleep_ok;
    logic wake;
    logic rst_wake;
    smc_wake_if wif ();

    function automatic logic mode_valid(input logic [2:0] m);
        mode_valid = (m == `SMC_MODE_IDLE) || (m == `SMC_MODE_PDOWN) ||
                     (m == `SMC_MODE_PSAVE) || (m == `SMC_MODE_STBY) ||
                     (m == `SMC_MODE_XSTBY);
    endfunction : mode_valid

    function automatic logic osc_stops(input logic [2:0] m);
        osc_stops = (m == `SMC_MODE_PDOWN) || (m == `SMC_MODE_PSAVE);
    endfunction : osc_stops

    // Mode being entered comes from control, a held sleep uses the latch
    function automatic logic [2:0] mode_d_sel(input smc_state_t s,
                                              input logic [2:0] c,
                                              input logic [2:0] m);
        mode_d_sel = (s == SMC_RUN) ? c : m;
    endfunction : mode_d_sel

    // Pin inputs pass two flops before any logic reads them
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            lvl1_q <= 4'h0;
            lvl2_q <= 4'h0;
            edg1_q <= 4'h0;
            edg2_q <= 4'h0;
            rst_sync_q <= 2'h0;
        end else begin
            sync1_q <= {pin_change, comm_req, card_evt, key_press, wdt_irq};
            sync2_q <= sync1_q;
            lvl1_q <= external_irq_lines;
            lvl2_q <= lvl1_q;
            edg1_q <= ext_irq_edge;
            edg2_q <= edg1_q;
            rst_sync_q <= {rst_sync_q[0], any_reset};
        end
    end
    assign rst_wake = rst_sync_q[1];

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q <= `SMC_CTRL_RESET;
        end else if (ctrl_we) begin
            ctrl_q <= ctrl_wdata;
        end
    end
    assign sleep_control_register = ctrl_q;

    assign sleep_ok = sleep_exec && ctrl_q[0] &&
                      mode_valid(ctrl_q[3:1]);

    assign wif.mode = mode_q;
    assign wake = wif.wake;

    smc_wake_qual u_qual (
        .mclk(mclk),
        .reset(reset),
        .wi(wif.qual),
        .ext_irq_lvl(lvl2_q),
        .ext_irq_edge(edg2_q),
        .pin_change(sync2_q[4]),
        .comm_req(sync2_q[3]),
        .card_evt(sync2_q[2]),
        .key_press(sync2_q[1]),
        .wdt_irq(sync2_q[0]),
        .t2_ovf(t2_ovf),
        .t2_cmp(t2_cmp),
        .timer_two_irq_mask(timer_two_irq_mask),
        .global_irq_en(global_irq_en),
        .mem_ready(mem_ready),
        .other_io(other_io)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            SMC_RUN: begin
                if (sleep_ok) begin
                    state_d = SMC_SLEEP;
                end
            end
            SMC_SLEEP: begin
                if (rst_wake) begin
                    state_d = SMC_RVEC;
                end else if (wake) begin
                    state_d = SMC_START;
                end
            end
            SMC_START: begin
                if (cnt_q == '0) begin
                    state_d = SMC_HALT;
                end
            end
            SMC_HALT: begin
                if (halt_q == 4'h1) begin
                    state_d = SMC_RUN;
                end
            end
            SMC_RVEC: begin
                state_d = SMC_RUN;
            end
            default: begin
                state_d = SMC_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= SMC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_q <= `SMC_MODE_IDLE;
        end else if (state_q == SMC_RUN && sleep_ok) begin
            mode_q <= ctrl_q[3:1];
        end
    end

    // Start-up wait: fuse count after oscillator stop, six in standby
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (state_q == SMC_SLEEP && wake) begin
            if (osc_stops(mode_q)) begin
                cnt_q <= clock_source_fuses;
            end else if (mode_q == `SMC_MODE_IDLE) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= STARTUP_W'(`SMC_STBY_CYCLES - 4'h1);
            end
        end else if (state_q == SMC_START && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            halt_q <= 4'h0;
        end else if (state_q == SMC_START) begin
            halt_q <= `SMC_HALT_CYCLES;
        end else if (state_q == SMC_HALT) begin
            halt_q <= halt_q - 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            resume_pulse <= 1'b0;
            vector_restart <= 1'b0;
        end else begin
            resume_pulse <= (state_q == SMC_HALT && halt_q == 4'h1);
            vector_restart <= (state_q == SMC_SLEEP && rst_wake);
        end
    end

    // Memories are not touched here; the core just stops while held
    assign sleeping = (state_q == SMC_SLEEP);
    assign cpu_hold = (state_q != SMC_RUN);

    // Clock domain gating per mode
    always_ff @(posedge mclk) begin
        if (reset) begin
            clk_en <= '1;
            t2_sync_clk_en <= 1'b1;
        end else if (state_d == SMC_SLEEP) begin
            clk_en.core <= 1'b0;
            clk_en.flash <= 1'b0;
            t2_sync_clk_en <= 1'b0;
            case (mode_d_sel(state_q, ctrl_q[3:1], mode_q))
                `SMC_MODE_IDLE: begin
                    clk_en.io <= 1'b1;
                    clk_en.fast <= 1'b1;
                    clk_en.asy <= 1'b1;
                    clk_en.main_osc <= 1'b1;
                    clk_en.timer_osc <= t2_enabled && t2_async;
                    t2_sync_clk_en <= 1'b1;
                end
                `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: begin
                    clk_en.io <= 1'b0;
                    clk_en.fast <= 1'b0;
                    // Power-save keeps the async domain, ext standby only
                    // when the timer runs from it
                    clk_en.asy <= (mode_d_sel(state_q, ctrl_q[3:1],
                        mode_q) == `SMC_MODE_PSAVE) ||
                        (t2_enabled && t2_async);
                    clk_en.timer_osc <= t2_enabled && t2_async;
                    clk_en.main_osc <= (mode_d_sel(state_q, ctrl_q[3:1],
                        mode_q) == `SMC_MODE_XSTBY) ||
                        (t2_enabled && !t2_async);
                    t2_sync_clk_en <= t2_enabled && !t2_async;
                end
                default: begin
                    clk_en.io <= 1'b0;
                    clk_en.fast <= 1'b0;
                    clk_en.asy <= 1'b0;
                    clk_en.timer_osc <= 1'b0;
                    clk_en.main_osc <= (mode_d_sel(state_q, ctrl_q[3:1],
                        mode_q) == `SMC_MODE_STBY);
                end
            endcase
        end else begin
            clk_en <= '1;
            t2_sync_clk_en <= 1'b1;
        end
    end

    a_enter_needs_en: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_RUN && !(sleep_exec && ctrl_q[0]))
        |=> state_q != SMC_SLEEP)
        else $error("sleep entered without enable");
    a_reserved_mode: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_RUN && !mode_valid(ctrl_q[3:1]))
        |=> state_q == SMC_RUN)
        else $error("reserved mode entered sleep");
    a_halt_four: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_START && cnt_q == '0)
        |=> (state_q == SMC_HALT) [*4] ##1 state_q == SMC_RUN)
        else $error("halt not four cycles");
    a_reset_vector: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_SLEEP && rst_wake)
        |=> vector_restart && !resume_pulse)
        else $error("reset during sleep did not restart");
    a_standby_six: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_SLEEP && !rst_wake && wake &&
         mode_q == `SMC_MODE_STBY)
        |=> state_q == SMC_START ##5 state_q == SMC_START
        ##1 state_q == SMC_HALT)
        else $error("standby wake not six cycles");
    a_idle_clocks: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_SLEEP && mode_q == `SMC_MODE_IDLE &&
         $past(state_q) == SMC_SLEEP)
        |-> !clk_en.core && clk_en.io && clk_en.fast)
        else $error("idle clock gating wrong");
    a_pdown_clocks: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_SLEEP && mode_q == `SMC_MODE_PDOWN &&
         $past(state_q) == SMC_SLEEP)
        |-> !clk_en.io && !clk_en.main_osc && !clk_en.asy)
        else $error("power-down clocks left running");
    a_fuse_delay: assert property (@(posedge mclk) disable iff (reset)
        (state_q == SMC_SLEEP && !rst_wake && wake &&
         mode_q == `SMC_MODE_PDOWN)
        |=> cnt_q == $past(clock_source_fuses))
        else $error("start-up count not loaded from fuses");
endmodule : smc_sleep_ctrl

/* verilog/smc_regs.svh */
// Timing counts and encodings for the sleep mode controller
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7
`define SMC_HALT_CYCLES 4'h4
`define SMC_STBY_CYCLES 4'h6
`define SMC_CTRL_RESET 4'h0
`endif

/* verilog/smc_pkg.sv */
// Types shared by the sleep mode controller files
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_RUN = 3'b000,
        SMC_SLEEP = 3'b001,
        SMC_START = 3'b011,
        SMC_HALT = 3'b010,
        SMC_RVEC = 3'b110
    } smc_state_t;
    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic fast;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } smc_clk_t;
endpackage : smc_pkg

/* verilog/smc_wake_if.sv */
// Wake qualification signals between controller and qualifier
`timescale 1ns/10ps
interface smc_wake_if;
    logic [2:0] mode;
    logic wake;
    modport ctrl (output mode, input wake);
    modport qual (input mode, output wake);
endinterface : smc_wake_if

/* verilog/smc_wake_qual.sv */
// Per-mode qualification of wake-up sources
`timescale 1ns/10ps
`include "smc_regs.svh"
module smc_wake_qual (
    input wire logic mclk, // Clock
    input wire logic reset, // Sync reset
    smc_wake_if.qual wi, // Mode in, wake out
    input wire logic [3:0] ext_irq_lvl, // Synced level irq lines
    input wire logic [3:0] ext_irq_edge, // Synced edge irq events
    input wire logic pin_change, // Synced pin change
    input wire logic comm_req, // Synced comm request
    input wire logic card_evt, // Synced card event
    input wire logic key_press, // Synced keypad
    input wire logic wdt_irq, // Watchdog irq
    input wire logic t2_ovf, // Timer two overflow
    input wire logic t2_cmp, // Timer two compare
    input wire logic [1:0] timer_two_irq_mask, // Ovf, cmp enables
    input wire logic global_irq_en, // Global enable
    input wire logic mem_ready, // Memory ready irq
    input wire logic other_io // Other peripheral irq
);
    logic idle;
    logic t2_mode;
    logic t2_wake;
    always_comb begin
        idle = (wi.mode == `SMC_MODE_IDLE);
        t2_mode = (wi.mode == `SMC_MODE_PSAVE) ||
                  (wi.mode == `SMC_MODE_XSTBY);
        t2_wake = global_irq_en &&
                  ((t2_ovf && timer_two_irq_mask[0]) ||
                   (t2_cmp && timer_two_irq_mask[1]));
        if (idle) begin
            wi.wake = |ext_irq_lvl || |ext_irq_edge || pin_change ||
                      comm_req || card_evt || key_press || wdt_irq ||
                      t2_wake || mem_ready || other_io;
        end else begin
            // Edge forms of the irq lines need a clock, so levels only
            wi.wake = |ext_irq_lvl || pin_change || comm_req ||
                      card_evt || key_press || wdt_irq ||
                      (t2_mode && t2_wake);
        end
    end
    a_no_edge_wake: assert property (@(posedge mclk) disable iff (reset)
        (!idle && ext_irq_edge != 4'h0 && ext_irq_lvl == 4'h0 && !pin_change
         && !comm_req && !card_evt && !key_press && !wdt_irq
         && !(t2_ovf || t2_cmp)) |-> !wi.wake)
        else $error("edge irq woke a deep sleep mode");
    a_t2_gate: assert property (@(posedge mclk) disable iff (reset)
        (wi.mode == `SMC_MODE_PSAVE && !global_irq_en && ext_irq_lvl == 4'h0
         && !pin_change && !comm_req && !card_evt && !key_press
         && !wdt_irq) |-> !wi.wake)
        else $error("timer woke power-save without global enable");
endmodule : smc_wake_qual

/* tb/smc_src_model.sv */
// Behavioural wake-source model facing the sleep controller
`timescale 1ns/10ps
module smc_src_model (
    input wire logic mclk, // Clock
    input wire logic on, // Assert the chosen source
    input wire logic [3:0] sel, // Source index
    input wire logic [1:0] lane, // Irq lane, timer event pick
    output logic [3:0] lvl, // Level irq lines
    output logic [3:0] edg, // Edge irq events
    output logic [7:0] misc // Pin,comm,card,key,wdt,t2,mem,io
);
    logic [15:0] v_q = 16'h0000;
    // Level held until the bench drops it, long enough for the syncs
    always @(posedge mclk) v_q <= on ? 16'h0001 << sel : 16'h0000;
    assign lvl = v_q[0] ? 4'h1 << lane : 4'h0;
    assign edg = v_q[1] ? 4'h1 << lane : 4'h0;
    assign misc = v_q[9:2];
endmodule : smc_src_model

/* tb/smc_sleep_ctrl_tb.sv */
// Self-checking bench for the sleep mode controller
`timescale 1ns/10ps
module smc_sleep_ctrl_tb;
    import smc_pkg::*;
    logic mclk = 0, reset = 1, sleep_exec = 0, ctrl_we = 0;
    logic [3:0] ctrl_wdata = 4'h0, sel = 4'h0, lvl, edg, scr;
    logic [15:0] fuses = 16'h0003;
    logic any_reset = 0, gie = 1, t2e = 1, t2a = 0, on = 0;
    logic [1:0] mask = 2'h3, lane = 2'h0;
    logic [7:0] misc;
    logic slp, hold, resp, vrst, tsync;
    smc_clk_t clk_en;
    int n_errors = 0, checked = 0;
    int modes [5] = '{0, 2, 3, 6, 7};
    logic [3:0] refuse [4] = '{4'h3, 4'h9, 4'hb, 4'h4};
    always #20 mclk = ~mclk;
    smc_src_model src (.mclk(mclk), .on(on), .sel(sel), .lane(lane),
        .lvl(lvl), .edg(edg), .misc(misc));
    smc_sleep_ctrl uut (.mclk(mclk), .reset(reset),
        .sleep_exec(sleep_exec), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
        .clock_source_fuses(fuses), .any_reset(any_reset),
        .external_irq_lines(lvl), .ext_irq_edge(edg),
        .pin_change(misc[0]), .comm_req(misc[1]), .card_evt(misc[2]),
        .key_press(misc[3]), .wdt_irq(misc[4]),
        .t2_ovf(misc[5] & ~lane[0]), .t2_cmp(misc[5] & lane[0]),
        .timer_two_irq_mask(mask), .global_irq_en(gie),
        .mem_ready(misc[6]), .other_io(misc[7]), .t2_enabled(t2e),
        .t2_async(t2a), .sleep_control_register(scr), .sleeping(slp),
        .cpu_hold(hold), .resume_pulse(resp), .vector_restart(vrst),
        .clk_en(clk_en), .t2_sync_clk_en(tsync));
    task automatic final_report();
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_cnt(string what, int exp, int got);
        checked++;
        if (got != exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick
    task automatic write_ctrl(logic [3:0] d);
        @(posedge mclk);
        ctrl_we <= 1'b1;
        ctrl_wdata <= d;
        @(posedge mclk);
        ctrl_we <= 1'b0;
        tick();
        chk("control", {4'h0, d}, {4'h0, scr});
    endtask : write_ctrl
    task automatic try_sleep(logic [3:0] d);
        write_ctrl(d);
        @(posedge mclk);
        sleep_exec <= 1'b1;
        @(posedge mclk);
        sleep_exec <= 1'b0;
        #1;
    endtask : try_sleep
    function automatic logic [6:0] exp_clk(int m);
        logic ta;
        logic ts;
        ta = t2e & t2a;
        ts = t2e & ~t2a;
        case (m)
            0: return {5'h07, 1'h1, ta};
            2: return 7'h00;
            3: return {5'h01, ts, ta};
            6: return 7'h02;
            default: return {4'h0, ta, 1'h1, ta};
        endcase
    endfunction : exp_clk
    function automatic bit exp_wake(int m, int s);
        if (s == 7) return (m == 0 || m == 3 || m == 7) && gie
            && mask[lane[0]];
        if (m == 0) return 1;
        return !(s == 1 || s >= 8);
    endfunction : exp_wake
    task automatic run_case(int m, int s);
        int n;
        bit w;
        @(posedge mclk);
        fuses <= 16'(1 + $urandom % 4);
        t2a <= 1'($urandom);
        // Power-save is only picked with the timer running
        t2e <= (m == 3) ? 1'b1 : 1'($urandom);
        lane <= 2'($urandom);
        mask <= 2'($urandom);
        gie <= (s == 7) ? 1'($urandom) : 1'b1;
        try_sleep({3'(m), 1'h1});
        w = exp_wake(m, s);
        chk("sleeping", 8'h01, {7'h00, slp});
        chk("clk_en", {1'h0, exp_clk(m)}, {1'h0, clk_en});
        if (m == 3) chk("t2 sync", {7'h00, t2e & ~t2a}, {7'h00, tsync});
        @(posedge mclk);
        sel <= 4'(s);
        on <= 1'b1;
        n = 0;
        while (slp === 1'b1 && n < 12) begin
            tick();
            n++;
        end
        chk("woken", {7'h00, w}, {7'h00, ~slp});
        if (w) begin
            n = 0;
            while (hold === 1'b1 && n < 40) begin
                n++;
                @(posedge mclk);
                on <= 1'b0;
                #1;
            end
            chk_cnt("wake cycles", (m == 0) ? 5 : (m == 2 || m == 3) ?
                int'(fuses) + 5 : 10, n);
            chk("resume", 8'h01, {7'h00, resp});
            chk("clk_en run", 8'h7f, {1'h0, clk_en});
            chk("control kept", {4'h0, 3'(m), 1'h1}, {4'h0, scr});
            write_ctrl({3'(m), 1'h0});
        end else begin
            // Unqualified source: leave sleep through a reset instead
            @(posedge mclk);
            on <= 1'b0;
            any_reset <= 1'b1;
            n = 0;
            while (vrst !== 1'b1 && n < 20) begin
                tick();
                n++;
            end
            chk("vector", 8'h01, {7'h00, vrst});
            chk("no resume", 8'h00, {7'h00, resp});
            @(posedge mclk);
            any_reset <= 1'b0;
            repeat (4) tick();
            chk("hold after reset", 8'h00, {7'h00, hold});
        end
    endtask : run_case
    initial begin
        void'($urandom(32'h39ec));
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        tick();
        chk("clk_en reset", 8'h7f, {1'h0, clk_en});
        chk("control reset", 8'h00, {4'h0, scr});
        for (int i = 0; i < 4; i++) begin
            try_sleep(refuse[i]);
            tick();
            chk("refused hold", 8'h00, {7'h00, hold});
            chk("refused clk", 8'h7f, {1'h0, clk_en});
        end
        repeat (2) begin
            foreach (modes[k]) begin
                for (int s = 0; s < 10; s++) begin
                    run_case(modes[k], s);
                end
            end
        end
        final_report();
    end
    initial begin
        #800000;
        n_errors++;
        final_report();
    end
endmodule : smc_sleep_ctrl_tb
